// ==== inc/event_counter_pkg.sv ====
// constants, types and behaviour summary for the pulse/event counter bank
// Behaviour
// - four independent counters, six decimal digits each
// - each counter links none or one input
// - each recognised pulse adds weight 1..9999, default 1
// - setpoint strobe increments any counter independently
// - setpoint may read and clear a counter
// - software load keeps link and weight untouched
// - counter contents readable at any time
// - single-edge mode one edge, transition both edges
// - polarity picks closing or opening edge
// - shared debounce 1..100 ms, default 10 ms
`default_nettype none
package event_counter_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_COUNTERS = 4;         // general counters in the bank
    localparam int NUM_INPUTS   = 14;        // digital_input_first .. digital_input_last
    localparam int COUNT_W      = 20;        // holds 0..999999 in binary
    localparam int WEIGHT_W     = 14;        // holds 1..9999
    localparam int SRC_W        = 4;         // 0 = none, 1..14 = linked input
    localparam int DEB_W        = 7;         // debounce milliseconds 1..100
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 32;

    // ************************************************************
    // value limits
    // ************************************************************
    localparam logic [COUNT_W-1:0]  COUNT_MODULUS = 20'hf4240;  // 1000000
    localparam logic [WEIGHT_W-1:0] WEIGHT_MIN    = 14'h0001;
    localparam logic [WEIGHT_W-1:0] WEIGHT_MAX    = 14'h270f;   // 9999
    localparam logic [DEB_W-1:0]    DEB_MIN_MS    = 7'h01;
    localparam logic [DEB_W-1:0]    DEB_MAX_MS    = 7'h64;      // 100
    localparam logic [SRC_W-1:0]    SRC_LAST      = 4'he;       // 14

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [WEIGHT_W-1:0]   WEIGHT_RST = 14'h0001;
    localparam logic [SRC_W-1:0]      SRC_RST    = 4'h0;       // none
    localparam logic [DEB_W-1:0]      DEB_RST_MS = 7'h0a;      // 10 ms
    localparam logic [NUM_INPUTS-1:0] MODE_RST   = 14'h0000;   // single-edge
    localparam logic [NUM_INPUTS-1:0] POL_RST    = 14'h0000;   // normal

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int DEB_TICK_NS   = 1000000;                    // 1 ms tick
    localparam int DEB_TICK_CYC  = DEB_TICK_NS / CLK_PERIOD_NS;

    // ************************************************************
    // register offsets and fields
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_COUNT0   = 8'h00;  // 0x00..0x03 counter values
    localparam logic [ADDR_W-1:0] OFS_CFG0     = 8'h04;  // 0x04..0x07 counter setup
    localparam logic [ADDR_W-1:0] OFS_DEBOUNCE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_MODE     = 8'h09;  // 1 = transition mode
    localparam logic [ADDR_W-1:0] OFS_POL      = 8'h0a;  // 1 = inverting
    localparam logic [ADDR_W-1:0] OFS_STATE    = 8'h0b;  // debounced input states
    localparam int CFG_WEIGHT_LSB = 0;
    localparam int CFG_SRC_LSB    = 16;

    // counter setup carried as one unit
    typedef struct packed {
        logic [SRC_W-1:0]    src;
        logic [WEIGHT_W-1:0] weight;
    } cnt_cfg_t;

    // register bus request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

endpackage
`default_nettype wire

// ==== core/event_counter_bank.sv ====
// bank of four debounced pulse/event counters with a register port
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module event_counter_bank #(
    parameter int DEB_TICK_CYCLES = event_counter_pkg::DEB_TICK_CYC  // cycles per ms
) (
    // clock and reset
    input  wire logic                                    I_REF_CLK,
    input  wire logic                                    I_ARST_N,
    // register port
    input  wire logic [event_counter_pkg::ADDR_W-1:0]    i_ADDR,
    input  wire logic [event_counter_pkg::DATA_W-1:0]    i_WDATA,
    input  wire logic                                    i_WR,
    input  wire logic                                    i_RD,
    output logic      [event_counter_pkg::DATA_W-1:0]    o_RDATA,
    // digital input pins, high = contact closed
    input  wire logic [event_counter_pkg::NUM_INPUTS-1:0] i_DIGITAL_INPUT,
    // setpoint controller strobes, one bit per counter
    input  wire logic [event_counter_pkg::NUM_COUNTERS-1:0] i_SP_INC,
    input  wire logic [event_counter_pkg::NUM_COUNTERS-1:0] i_SP_CLR,
    // counter values and debounced states
    output logic      [event_counter_pkg::NUM_COUNTERS-1:0][event_counter_pkg::COUNT_W-1:0]
                                                         o_COUNT,
    output logic      [event_counter_pkg::NUM_INPUTS-1:0] o_DI_STATE
);

    // ************************************************************
    // local shorthands for the package sizes
    // ************************************************************
    localparam int NI = event_counter_pkg::NUM_INPUTS;
    localparam int NC = event_counter_pkg::NUM_COUNTERS;
    localparam int CW = event_counter_pkg::COUNT_W;
    localparam int DW = event_counter_pkg::DEB_W;
    // one below the period because the prescaler counts from zero
    localparam logic [13:0] TICK_LAST = 14'(DEB_TICK_CYCLES - 1);

    // ************************************************************
    // bus request bundle
    // ************************************************************
    // the bundle only renames the port signals; no flop sits here, so a
    // strobe acts at the very edge at which the master presents it
    event_counter_pkg::bus_req_t req;            // incoming request, same clock
    assign req = '{wr: i_WR, rd: i_RD, addr: i_ADDR, wdata: i_WDATA};

    // ************************************************************
    // configuration registers
    // ************************************************************
    event_counter_pkg::cnt_cfg_t cfg_reg  [NC];  // per-counter link and weight
    event_counter_pkg::cnt_cfg_t cfg_next [NC];
    logic [DW-1:0] deb_reg, deb_next;            // shared debounce in ms
    logic [NI-1:0] mode_reg, mode_next;          // 1 = transition mode
    logic [NI-1:0] pol_reg, pol_next;            // 1 = inverting

    // clamp weight into its legal span
    // a zero weight would leave a linked counter frozen, so clamp, not refuse
    function automatic logic [event_counter_pkg::WEIGHT_W-1:0] clamp_weight(
        input logic [event_counter_pkg::WEIGHT_W-1:0] w);
        if (w < event_counter_pkg::WEIGHT_MIN) begin
            return event_counter_pkg::WEIGHT_MIN;
        end else if (w > event_counter_pkg::WEIGHT_MAX) begin
            return event_counter_pkg::WEIGHT_MAX;
        end
        return w;
    endfunction

    // configuration next values from software writes
    // writes to unmapped offsets leave every setup register as it is
    always_comb begin
        logic [DW-1:0] d;
        d         = req.wdata[DW-1:0];
        deb_next  = deb_reg;
        mode_next = mode_reg;
        pol_next  = pol_reg;
        for (int c = 0; c < NC; c++) begin
            cfg_next[c] = cfg_reg[c];
            if (req.wr && req.addr == event_counter_pkg::OFS_CFG0 + 8'(c)) begin
                // out-of-range source falls back to no link
                cfg_next[c].src = (req.wdata[event_counter_pkg::CFG_SRC_LSB +: 4]
                                   > event_counter_pkg::SRC_LAST) ? 4'h0 :
                                  req.wdata[event_counter_pkg::CFG_SRC_LSB +: 4];
                cfg_next[c].weight = clamp_weight(
                    req.wdata[event_counter_pkg::CFG_WEIGHT_LSB +: 14]);
            end
        end
        if (req.wr && req.addr == event_counter_pkg::OFS_DEBOUNCE) begin
            // clamp the debounce into 1..100 ms
            if (d < event_counter_pkg::DEB_MIN_MS) begin
                deb_next = event_counter_pkg::DEB_MIN_MS;
            end else if (d > event_counter_pkg::DEB_MAX_MS) begin
                deb_next = event_counter_pkg::DEB_MAX_MS;
            end else begin
                deb_next = d;
            end
        end
        if (req.wr && req.addr == event_counter_pkg::OFS_MODE) begin
            // one bit per input; bits above the last input are dropped
            mode_next = req.wdata[NI-1:0];
        end
        if (req.wr && req.addr == event_counter_pkg::OFS_POL) begin
            // stored even in transition mode, where the edge logic ignores it
            pol_next = req.wdata[NI-1:0];
        end
    end

    // configuration registers
    // setup survives counter loads and clears; only reset restores it
    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            for (int c = 0; c < NC; c++) begin
                cfg_reg[c] <= '{src: event_counter_pkg::SRC_RST,
                                weight: event_counter_pkg::WEIGHT_RST};
            end
            deb_reg  <= event_counter_pkg::DEB_RST_MS;
            mode_reg <= event_counter_pkg::MODE_RST;
            pol_reg  <= event_counter_pkg::POL_RST;
        end else begin
            cfg_reg  <= cfg_next;
            deb_reg  <= deb_next;
            mode_reg <= mode_next;
            pol_reg  <= pol_next;
        end
    end

    // ************************************************************
    // millisecond tick shared by all debouncers
    // ************************************************************
    logic [13:0] pre_reg, pre_next;              // prescaler
    logic        tick_reg, tick_next;            // one-cycle ms pulse
    // the prescaler free-runs, so a pin change waits up to one tick for its
    // first ms count; the debounce time is therefore exact to within one ms

    always_comb begin
        tick_next = (pre_reg == TICK_LAST);
        pre_next  = tick_next ? 14'h0000 : pre_reg + 14'h0001;
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pre_reg  <= 14'h0000;
            tick_reg <= 1'b0;
        end else begin
            pre_reg  <= pre_next;
            tick_reg <= tick_next;
        end
    end

    // ************************************************************
    // per-input synchroniser, debouncer and edge recogniser
    // ************************************************************
    logic [NI-1:0] sync1_reg, sync2_reg;         // two-flop pin synchroniser
    logic [NI-1:0] stable_reg, stable_next;      // accepted input state
    logic [DW-1:0] dcnt_reg [NI];                // ms the input has differed
    logic [DW-1:0] dcnt_next [NI];
    logic [NI-1:0] ev_reg, ev_next;              // recognised pulse events

    generate
        for (genvar i = 0; i < NI; i++) begin : g_in
            // accept a new level only after it held through as many ms ticks as the debounce time
            // a bounce back to the accepted level restarts the count, so
            // chatter no longer than the debounce time less one ms never reaches a counter
            always_comb begin
                stable_next[i] = stable_reg[i];
                dcnt_next[i]   = dcnt_reg[i];
                ev_next[i]     = 1'b0;
                if (sync2_reg[i] == stable_reg[i]) begin
                    dcnt_next[i] = '0;
                end else if (tick_reg) begin
                    // the first tick after a change already counts as one ms
                    if (dcnt_reg[i] + 7'h01 >= deb_reg) begin
                        stable_next[i] = sync2_reg[i];
                        dcnt_next[i]   = '0;
                        if (mode_reg[i]) begin
                            ev_next[i] = 1'b1;
                        end else begin
                            // closing edge normally, opening edge when inverting
                            ev_next[i] = (sync2_reg[i] != pol_reg[i]);
                        end
                    end else begin
                        dcnt_next[i] = dcnt_reg[i] + 7'h01;
                    end
                end
            end

            // only sync2 feeds logic; sync1 is left a full cycle to settle
            always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
                if (!I_ARST_N) begin
                    sync1_reg[i]  <= 1'b0;
                    sync2_reg[i]  <= 1'b0;
                    stable_reg[i] <= 1'b0;
                    dcnt_reg[i]   <= '0;
                    ev_reg[i]     <= 1'b0;
                end else begin
                    sync1_reg[i]  <= i_DIGITAL_INPUT[i];
                    sync2_reg[i]  <= sync1_reg[i];
                    stable_reg[i] <= stable_next[i];
                    dcnt_reg[i]   <= dcnt_next[i];
                    ev_reg[i]     <= ev_next[i];
                end
            end
        end
    endgenerate

    // ************************************************************
    // counters
    // ************************************************************
    // counters are binary, not decimal: six digits are kept by wrapping
    // at one million rather than by carries between digits
    logic [CW-1:0] cnt_reg  [NC];                // counter values, 0..999999
    logic [CW-1:0] cnt_next [NC];
    logic [NI:0]   ev_ext;                       // index 0 stands for no link
    assign ev_ext = {ev_reg, 1'b0};

    generate
        for (genvar c = 0; c < NC; c++) begin : g_cnt
            // software load beats setpoint clear, which beats any addition;
            // a pulse and a setpoint increment in one cycle both count
            always_comb begin
                logic [CW:0] sum;
                sum = {1'b0, cnt_reg[c]};
                if (ev_ext[cfg_reg[c].src]) begin
                    sum = sum + {7'h00, cfg_reg[c].weight};
                end
                if (i_SP_INC[c]) begin
                    sum = sum + 21'h000001;
                end
                // one wrap suffices: weight plus one stays far below a million
                if (sum >= {1'b0, event_counter_pkg::COUNT_MODULUS}) begin
                    sum = sum - {1'b0, event_counter_pkg::COUNT_MODULUS};
                end
                cnt_next[c] = sum[CW-1:0];
                if (i_SP_CLR[c]) begin
                    cnt_next[c] = '0;
                end
                if (req.wr && req.addr == event_counter_pkg::OFS_COUNT0 + 8'(c)) begin
                    // loads only the value; setup registers stay as they are
                    // all 32 bits are compared so stray high bits cannot slip a value in
                    if (req.wdata >= 32'(event_counter_pkg::COUNT_MODULUS)) begin
                        cnt_next[c] = '0;
                    end else begin
                        cnt_next[c] = req.wdata[CW-1:0];
                    end
                end
            end

            // counts start from zero; setup lives in its own registers
            always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
                if (!I_ARST_N) begin
                    cnt_reg[c] <= '0;
                end else begin
                    cnt_reg[c] <= cnt_next[c];
                end
            end
        end
    endgenerate

    // ************************************************************
    // read port and status outputs
    // ************************************************************
    logic [31:0] rdata_reg, rdata_next;          // read data, valid one cycle
    // reads have no side effects, so polling never disturbs a count
    // counter and setup offsets match in the loop, single registers below

    always_comb begin
        rdata_next = 32'h00000000;               // idle and unmapped read zero
        if (req.rd) begin
            for (int c = 0; c < NC; c++) begin
                if (req.addr == event_counter_pkg::OFS_COUNT0 + 8'(c)) begin
                    rdata_next = {12'h000, cnt_reg[c]};
                end
                if (req.addr == event_counter_pkg::OFS_CFG0 + 8'(c)) begin
                    rdata_next = {12'h000, cfg_reg[c].src, 2'b00, cfg_reg[c].weight};
                end
            end
            unique case (req.addr)
                event_counter_pkg::OFS_DEBOUNCE: rdata_next = {25'h0, deb_reg};
                event_counter_pkg::OFS_MODE:     rdata_next = {18'h0, mode_reg};
                event_counter_pkg::OFS_POL:      rdata_next = {18'h0, pol_reg};
                event_counter_pkg::OFS_STATE:    rdata_next = {18'h0, stable_reg};
                default: ;
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // every output is a plain copy of a register, never of logic
    assign o_RDATA    = rdata_reg;
    assign o_DI_STATE = stable_reg;
    // setpoint logic tests the counter straight from its register
    generate
        for (genvar c = 0; c < NC; c++) begin : g_out
            assign o_COUNT[c] = cnt_reg[c];
        end
    endgenerate

endmodule
`default_nettype wire

// ==== testbench/contact_model.sv ====
// behavioural model of the dry contacts wired to the digital inputs
`timescale 1ns/1ps
`default_nettype none
module contact_model (
    // clock the contacts are moved against
    input  wire logic        i_clk,
    // contact levels, high = closed
    output logic      [13:0] o_pins
);
    // ************************************************************
    // contact movement
    // ************************************************************
    // all contacts open at power-up
    initial o_pins = 14'h0000;

    // move one contact just after an edge, then hold it for settle cycles
    task automatic set_contact(input int idx, input logic lvl, input int settle);
        @(posedge i_clk);
        o_pins[idx] <= lvl;
        repeat (settle) @(posedge i_clk);
    endtask

    // short chatter: closes briefly then falls open again
    task automatic chatter(input int idx, input int len);
        set_contact(idx, 1'b1, len);
        set_contact(idx, 1'b0, 1);
    endtask
endmodule
`default_nettype wire

// ==== testbench/event_counter_bank_monitor.sv ====
// concurrent checks on the ports of the event counter bank
`timescale 1ns/1ps
`default_nettype none
module event_counter_bank_monitor #(
    parameter int DEB_TICK_CYCLES = 10000  // kept in step with the design
) (
    // clock and reset
    input wire logic             I_REF_CLK,
    input wire logic             I_ARST_N,
    // register port
    input wire logic [7:0]       i_ADDR,
    input wire logic [31:0]      i_WDATA,
    input wire logic             i_WR,
    input wire logic             i_RD,
    input wire logic [31:0]      o_RDATA,
    // pins and setpoint strobes
    input wire logic [13:0]      i_DIGITAL_INPUT,
    input wire logic [3:0]       i_SP_INC,
    input wire logic [3:0]       i_SP_CLR,
    // counter values and states
    input wire logic [3:0][19:0] o_COUNT,
    input wire logic [13:0]      o_DI_STATE
);
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_ARST_N);

    property p_rd_idle; !$past(i_RD) |-> o_RDATA == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    property p_rd_cnt; i_RD && i_ADDR == 8'h00 |=> o_RDATA == {12'h0, $past(o_COUNT[0])};
    endproperty
    a_rd_cnt: assert property (p_rd_cnt)
        else $error("counter read wrong");
    property p_rd_state; i_RD && i_ADDR == 8'h0b |=> o_RDATA == {18'h0, $past(o_DI_STATE)};
    endproperty
    a_rd_state: assert property (p_rd_state)
        else $error("state read wrong");
    property p_load; i_WR && i_ADDR == 8'h00 && i_WDATA < 32'h000f4240
        |=> o_COUNT[0] == $past(i_WDATA[19:0]); endproperty
    a_load: assert property (p_load)
        else $error("counter load wrong");
    property p_clear; i_SP_CLR[0] && !(i_WR && i_ADDR == 8'h00) |=> o_COUNT[0] == 20'h0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("setpoint clear missed");
    property p_inc; i_SP_INC[3] && !i_SP_CLR[3] && !(i_WR && i_ADDR == 8'h03)
        |=> o_COUNT[3] != $past(o_COUNT[3]); endproperty
    a_inc: assert property (p_inc)
        else $error("setpoint increment missed");
    property p_range; o_COUNT[2] < 20'hf4240; endproperty
    a_range: assert property (p_range)
        else $error("counter beyond six digits");
    // a new state must come from the synchronised pin level, never from nowhere
    property p_deb; $changed(o_DI_STATE[0]) |-> o_DI_STATE[0] == $past(i_DIGITAL_INPUT[0], 3);
    endproperty
    a_deb: assert property (p_deb)
        else $error("state change without pin level");
endmodule
bind event_counter_bank event_counter_bank_monitor #(.DEB_TICK_CYCLES(DEB_TICK_CYCLES)) mon_u (
    .I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N), .i_ADDR(i_ADDR), .i_WDATA(i_WDATA),
    .i_WR(i_WR), .i_RD(i_RD), .o_RDATA(o_RDATA), .i_DIGITAL_INPUT(i_DIGITAL_INPUT),
    .i_SP_INC(i_SP_INC), .i_SP_CLR(i_SP_CLR), .o_COUNT(o_COUNT), .o_DI_STATE(o_DI_STATE));
`default_nettype wire

// ==== testbench/event_counter_bank_bench.sv ====
// self-checking bench for the event counter bank
`timescale 1ns/1ps
`default_nettype none
module event_counter_bank_bench;
    // ************************************************************
    // signals
    // ************************************************************
    logic             ref_clk;   // 10 MHz
    logic             arst_n;    // active low reset
    logic [7:0]       addr;      // register port
    logic [31:0]      wdata;
    logic             wr;
    logic             rd;
    logic [31:0]      rdata;
    logic [13:0]      pins;      // contact levels from the model
    logic [3:0]       sp_inc;    // setpoint strobes
    logic [3:0]       sp_clr;
    logic [3:0][19:0] count;
    logic [13:0]      di_state;
    int               fails;
    int               n_tests;
    int               cycles;    // timeout counter

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // short ms tick keeps each debounce to a few cycles
    contact_model contacts_u (.i_clk(ref_clk), .o_pins(pins));
    event_counter_bank #(.DEB_TICK_CYCLES(4)) dut_u (
        .I_REF_CLK(ref_clk), .I_ARST_N(arst_n), .i_ADDR(addr), .i_WDATA(wdata),
        .i_WR(wr), .i_RD(rd), .o_RDATA(rdata), .i_DIGITAL_INPUT(pins),
        .i_SP_INC(sp_inc), .i_SP_CLR(sp_clr), .o_COUNT(count), .o_DI_STATE(di_state));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        chk(what, rdata, exp);
    endtask
    task automatic chk_cnt(input int c, input logic [19:0] exp);
        #1;  // look after the edge's updates have settled
        chk("count", {12'h0, count[c]}, {12'h0, exp});
    endtask
    task automatic final_report;
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            final_report;
        end
    end

    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        arst_n = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        sp_inc = 4'h0;
        sp_clr = 4'h0;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd_reg(8'h04, 32'h00000001, "setup0");
        rd_reg(8'h08, 32'h0000000a, "debounce");
        rd_reg(8'h00, 32'h0, "count0");
        // counter 0 on the first input, weight 5, preset near the wrap
        wr_reg(8'h08, 32'h1);
        wr_reg(8'h04, 32'h00010005);
        wr_reg(8'h06, 32'h000e270f);
        wr_reg(8'h00, 32'h000f423e);
        rd_reg(8'h00, 32'h000f423e, "preset0");
        rd_reg(8'h04, 32'h00010005, "setup0 kept");
        contacts_u.set_contact(0, 1'b1, 24);
        chk_cnt(0, 20'h3);
        contacts_u.set_contact(0, 1'b0, 24);
        chk_cnt(0, 20'h3);
        // inverting: only the opening counts
        wr_reg(8'h0a, 32'h1);
        contacts_u.set_contact(0, 1'b1, 24);
        chk_cnt(0, 20'h3);
        rd_reg(8'h0b, 32'h1, "states");
        chk("di state", {18'h0, di_state}, 32'h1);
        contacts_u.set_contact(0, 1'b0, 24);
        chk_cnt(0, 20'h8);
        // transition mode: both edges count
        wr_reg(8'h09, 32'h1);
        contacts_u.set_contact(0, 1'b1, 24);
        contacts_u.set_contact(0, 1'b0, 24);
        chk_cnt(0, 20'h12);
        chk_cnt(1, 20'h0);
        // last input drives counter 2 with the top weight
        contacts_u.set_contact(13, 1'b1, 24);
        chk_cnt(2, 20'h0270f);
        contacts_u.set_contact(13, 1'b0, 24);
        // chatter far shorter than a 3 ms debounce is dropped
        wr_reg(8'h08, 32'h3);
        contacts_u.chatter(13, 3);
        repeat (30) @(posedge ref_clk);
        chk_cnt(2, 20'h0270f);
        // setpoint strobes back to back, then a clear
        @(posedge ref_clk);
        sp_inc <= 4'hc;
        @(posedge ref_clk);
        sp_inc <= 4'h8;
        @(posedge ref_clk);
        sp_inc <= 4'h0;
        sp_clr <= 4'h1;
        @(posedge ref_clk);
        sp_clr <= 4'h0;
        #1;
        chk_cnt(3, 20'h2);
        chk_cnt(2, 20'h02710);
        chk_cnt(0, 20'h0);
        rd_reg(8'h06, 32'h000e270f, "setup2 kept");
        rd_reg(8'h20, 32'h0, "unmapped");
        // illegal source and zero weight fall back; oversized load gives zero
        wr_reg(8'h07, 32'h000f0000);
        rd_reg(8'h07, 32'h00000001, "setup3 clamped");
        wr_reg(8'h01, 32'h00100005);
        chk_cnt(1, 20'h0);
        wr_reg(8'h02, 32'h0);
        chk_cnt(2, 20'h0);
        final_report;
    end
endmodule
`default_nettype wire
